// ==== core/ulm_status.sv ====
`timescale 1ns/1ns
`default_nettype none

module ulm_status
  import ulm_pkg::*;
#(
  parameter int DEPTH       = 64,
  parameter int CHAR_CYCLES = 1100
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic               reg_rd,
  input  wire logic               reg_wr,
  input  wire logic [BYTE_W-1:0]  reg_wdata,
  output logic      [RDATA_W-1:0] reg_rdata,
  input  wire logic               rx_done,
  input  wire logic [BYTE_W-1:0]  rx_char,
  input  wire logic               rx_parity_bad,
  input  wire logic               rx_stop_bit,
  input  wire logic               rx_line,
  input  wire logic               dsr_n,
  output logic                    line_status_irq,
  output logic                    modem_status_irq
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int BW = 16;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [BW-1:0] BRK_CNT  = BW'(CHAR_CYCLES);

  // Exact offset match, shared by every register decode
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs
  );
    return addr == ofs;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [AW-1:0]      wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [CW-1:0]      count_r, count_nxt;
  logic               head_load_r, head_load_nxt;
  logic               pe_r, pe_nxt, fe_r, fe_nxt, bi_r, bi_nxt, oe_r, oe_nxt;
  logic [BYTE_W-1:0]  ier_r, ier_nxt;
  logic               dsr_meta_r, dsr_sync_r, dsr_prev_r, handshake_change_flag_r, handshake_change_flag_nxt;
  logic [BW-1:0]      brk_cnt_r, brk_cnt_nxt;
  logic [RDATA_W-1:0] rdata_nxt;
  logic               lsi_nxt, msi_nxt;

  logic               rd_rbr, rd_ier, rd_lsr, rd_msr, wr_ier;
  logic               empty, full, pop, push, push_req, brk_evt;
  logic [ENT_W-1:0]   ent_wdata, ram_q;
  logic [BYTE_W-1:0]  lsr_byte, msr_byte, sel_byte;

  ulm_ram #(.W(ENT_W), .AW(AW)) u_ram (
    .clock (clock),
    .we    (push),
    .waddr (wr_ptr_r),
    .wdata (ent_wdata),
    .raddr (rd_ptr_nxt),
    .q     (ram_q)
  );

  // ----------------------------------------------------------------
  // Register decode and receive queue control
  // ----------------------------------------------------------------
  always_comb begin
    rd_rbr   = reg_rd && addr_hit(reg_addr, OFS_RBR);
    rd_ier   = reg_rd && addr_hit(reg_addr, OFS_IER);
    rd_lsr   = reg_rd && addr_hit(reg_addr, OFS_LSR);
    rd_msr   = reg_rd && addr_hit(reg_addr, OFS_MSR);
    wr_ier   = reg_wr && addr_hit(reg_addr, OFS_IER);  // Status writes fall through
    empty    = (count_r == '0);
    full     = (count_r == FULL_CNT);
    pop      = rd_rbr && !empty;
    brk_evt  = !rx_line && (brk_cnt_r == BRK_CNT - 1'b1);
    push_req = rx_done || brk_evt;
    push     = push_req && !full;
    ent_wdata = '0;
    if (rx_done) begin
      ent_wdata[BYTE_W-1:0] = rx_char;
      ent_wdata[ENT_PE]     = rx_parity_bad;
      ent_wdata[ENT_FE]     = !rx_stop_bit;
    end
    ent_wdata[ENT_BI] = brk_evt;
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    count_nxt  = count_r + CW'(push) - CW'(pop);
    // A new entry becomes head after a pop or a push into an empty queue
    head_load_nxt = (count_nxt != '0) && (pop || (empty && push));
  end

  // ----------------------------------------------------------------
  // Flags, enables, handshake and break timing
  // ----------------------------------------------------------------
  always_comb begin
    pe_nxt   = (pe_r & ~rd_lsr) | (head_load_r & ram_q[ENT_PE]);
    fe_nxt   = (fe_r & ~rd_lsr) | (head_load_r & ram_q[ENT_FE]);
    bi_nxt   = (bi_r & ~rd_lsr) | (head_load_r & ram_q[ENT_BI]);
    oe_nxt   = (oe_r & ~rd_lsr) | (push_req & full);
    ier_nxt  = wr_ier ? reg_wdata : ier_r;
    handshake_change_flag_nxt = (handshake_change_flag_r & ~rd_msr) | (dsr_sync_r ^ dsr_prev_r);
    if (rx_line) begin
      brk_cnt_nxt = '0;
    end else if (brk_cnt_r != BRK_CNT) begin
      brk_cnt_nxt = brk_cnt_r + 1'b1;
    end else begin
      brk_cnt_nxt = brk_cnt_r;
    end
    lsi_nxt = ier_nxt[IER_RLS] & (pe_nxt | fe_nxt | bi_nxt | oe_nxt);
    msi_nxt = ier_nxt[IER_MS] & handshake_change_flag_nxt;
  end

  // ----------------------------------------------------------------
  // Read data, byte repeated on all four lanes
  // ----------------------------------------------------------------
  always_comb begin
    lsr_byte           = '0;
    lsr_byte[LSR_DR]   = !empty;
    lsr_byte[LSR_OE]   = oe_r;
    lsr_byte[LSR_PE]   = pe_r;
    lsr_byte[LSR_FE]   = fe_r;
    lsr_byte[LSR_BI]   = bi_r;
    msr_byte           = '0;
    msr_byte[MSR_HANDSHAKE_CHANGE_FLAG] = handshake_change_flag_r;
    msr_byte[MSR_DSR]  = !dsr_sync_r;
    if (rd_rbr) begin
      sel_byte = ram_q[BYTE_W-1:0];
    end else if (rd_ier) begin
      sel_byte = ier_r;
    end else if (rd_lsr) begin
      sel_byte = lsr_byte;
    end else if (rd_msr) begin
      sel_byte = msr_byte;
    end else begin
      sel_byte = '0;
    end
    rdata_nxt = reg_rd ? {4{sel_byte}} : reg_rdata;
  end

  // Receive queue pointers, fill level and head tracking
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      count_r     <= '0;
      head_load_r <= 1'b0;
    end else begin
      wr_ptr_r    <= wr_ptr_nxt;
      rd_ptr_r    <= rd_ptr_nxt;
      count_r     <= count_nxt;
      head_load_r <= head_load_nxt;
    end
  end

  // Line error flags, enables and line interrupt
  always_ff @(posedge clock) begin
    if (rst) begin
      pe_r            <= 1'b0;
      fe_r            <= 1'b0;
      bi_r            <= 1'b0;
      oe_r            <= 1'b0;
      ier_r           <= IER_RST;
      line_status_irq <= 1'b0;
    end else begin
      pe_r            <= pe_nxt;
      fe_r            <= fe_nxt;
      bi_r            <= bi_nxt;
      oe_r            <= oe_nxt;
      ier_r           <= ier_nxt;
      line_status_irq <= lsi_nxt;
    end
  end

  // Handshake synchroniser, change flag and modem interrupt
  always_ff @(posedge clock) begin
    if (rst) begin
      dsr_meta_r       <= DSR_N_RST;
      dsr_sync_r       <= DSR_N_RST;
      dsr_prev_r       <= DSR_N_RST;
      handshake_change_flag_r           <= 1'b0;
      modem_status_irq <= 1'b0;
    end else begin
      dsr_meta_r       <= dsr_n;
      dsr_sync_r       <= dsr_meta_r;
      dsr_prev_r       <= dsr_sync_r;
      handshake_change_flag_r           <= handshake_change_flag_nxt;
      modem_status_irq <= msi_nxt;
    end
  end

  // Break timer on the receive line
  always_ff @(posedge clock) begin
    if (rst) begin
      brk_cnt_r <= '0;
    end else begin
      brk_cnt_r <= brk_cnt_nxt;
    end
  end

  // Registered read data, held between reads
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

endmodule

`default_nettype wire

// ==== core/ulm_pkg.sv ====
package ulm_pkg;

  // ----------------------------------------------------------------
  // Register map and widths
  // ----------------------------------------------------------------
  localparam int         ADDR_W  = 8;
  localparam int         BYTE_W  = 8;
  localparam int         RDATA_W = 32;
  localparam logic [7:0] OFS_RBR = 8'h00;  // Receive data, read pops
  localparam logic [7:0] OFS_IER = 8'h04;  // Interrupt enables
  localparam logic [7:0] OFS_LSR = 8'h14;  // Line status
  localparam logic [7:0] OFS_MSR = 8'h18;  // Modem status

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LSR_DR   = 0;
  localparam int LSR_OE   = 1;
  localparam int LSR_PE   = 2;
  localparam int LSR_FE   = 3;
  localparam int LSR_BI   = 4;
  localparam int MSR_HANDSHAKE_CHANGE_FLAG = 1;
  localparam int MSR_DSR  = 5;
  localparam int IER_RLS  = 2;
  localparam int IER_MS   = 3;

  // Receive entry layout: data byte plus three error bits
  localparam int ENT_PE = 8;
  localparam int ENT_FE = 9;
  localparam int ENT_BI = 10;
  localparam int ENT_W  = 11;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IER_RST   = 8'h00;
  localparam logic       DSR_N_RST = 1'b1;  // Inactive level of the handshake input

endpackage

// ==== core/ulm_ram.sv ====
`timescale 1ns/1ns
`default_nettype none

module ulm_ram
  import ulm_pkg::*;
#(
  parameter int W  = ENT_W,
  parameter int AW = 6
) (
  input  wire logic          clock,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  q
);

  logic [W-1:0] mem [2**AW];
  logic [W-1:0] q_nxt;

  // Read with write-through so a word written to the head shows at once
  always_comb begin
    if (we && (waddr == raddr)) begin
      q_nxt = wdata;
    end else begin
      q_nxt = mem[raddr];
    end
  end

  // Storage and registered read port
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    q <= q_nxt;
  end

endmodule

`default_nettype wire

// ==== test/ulm_status_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module ulm_status_props
  import ulm_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        rx_done,
  input wire logic        rx_line,
  input wire logic        dsr_n,
  input wire logic        line_status_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Read decodes and a cycle that starts no receive, break or pop that could set a line flag
  logic lsr_rd, msr_rd, calm;
  assign lsr_rd = reg_rd && reg_addr == OFS_LSR;
  assign msr_rd = reg_rd && reg_addr == OFS_MSR;
  assign calm = !rx_done && rx_line && !(reg_rd && reg_addr == OFS_RBR);
  sequence calm3;
    calm[*3];
  endsequence
  dr_after_rx_a: assert property (rx_done ##1 !reg_rd ##1 lsr_rd |=> reg_rdata[LSR_DR])
    else $error("data ready missing");
  irq_clear_a: assert property (calm3 ##0 lsr_rd |=> !line_status_irq)
    else $error("line irq kept");
  flags_clear_a: assert property (calm3 ##0 lsr_rd ##1 calm ##1 (calm && lsr_rd)
    |=> reg_rdata[4:1] == 4'h0) else $error("flags kept");
  wr_null_a: assert property (calm3 ##0 lsr_rd ##1 (calm && !reg_rd)[*3]
    ##1 (calm && lsr_rd) |=> reg_rdata[4:1] == 4'h0) else $error("write set flags");
  dsr_level_a: assert property ($stable(dsr_n)[*4] ##0 msr_rd
    |=> reg_rdata[MSR_DSR] == !$past(dsr_n)) else $error("dsr level wrong");
  handshake_change_flag_set_a: assert property ($changed(dsr_n) && !$past(rst) ##1 (!msr_rd)[*6]
    ##1 msr_rd |=> reg_rdata[MSR_HANDSHAKE_CHANGE_FLAG]) else $error("change flag missing");
  handshake_change_flag_clear_a: assert property ($stable(dsr_n)[*7] ##0 msr_rd ##1 $stable(dsr_n)
    ##1 ($stable(dsr_n) && msr_rd) |=> !reg_rdata[MSR_HANDSHAKE_CHANGE_FLAG]) else $error("change kept");
  msr_wr_null_a: assert property ($stable(dsr_n)[*7] ##0 msr_rd
    ##1 (!msr_rd && $stable(dsr_n))[*3]
    ##1 ($stable(dsr_n) && msr_rd) |=> !reg_rdata[MSR_HANDSHAKE_CHANGE_FLAG]) else $error("write set change");
endmodule
`default_nettype wire

// ==== test/ulm_peer.sv ====
`timescale 1ns/1ns
`default_nettype none
module ulm_peer (
  input  wire logic  clock,
  output logic       rx_done,
  output logic [7:0] rx_char,
  output logic       rx_parity_bad,
  output logic       rx_stop_bit,
  output logic       rx_line,
  output logic       dsr_n
);
  // Idle levels
  initial begin
    rx_done = 1'b0;
    rx_char = 8'h00;
    rx_parity_bad = 1'b0;
    rx_stop_bit = 1'b1;
    rx_line = 1'b1;
    dsr_n = 1'b1;
  end
  // One character; qualifiers turn to junk once the pulse is over
  task automatic send(input logic [7:0] c, input logic pe, input logic fe);
    @(posedge clock);
    rx_done <= 1'b1;
    rx_char <= c;
    rx_parity_bad <= pe;
    rx_stop_bit <= !fe;
    @(posedge clock);
    rx_done <= 1'b0;
    rx_char <= ~c;
    rx_parity_bad <= !pe;
    rx_stop_bit <= fe;
  endtask
  // Line held low for n cycles
  task automatic brk(input int n);
    @(posedge clock);
    rx_line <= 1'b0;
    repeat (n) @(posedge clock);
    rx_line <= 1'b1;
  endtask
  task automatic dsr(input logic v);
    @(posedge clock);
    dsr_n <= v;
  endtask
endmodule
`default_nettype wire

// ==== test/ulm_status_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module ulm_status_bench
  import ulm_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst;
  logic [7:0]  reg_addr, reg_wdata, rx_char;
  logic        reg_rd, reg_wr;
  logic [31:0] reg_rdata;
  logic        rx_done, rx_parity_bad, rx_stop_bit, rx_line, dsr_n, ls_irq, ms_irq;
  int          miscompares = 0, n_tests = 0, cycles = 0;
  always #50 clock = ~clock;
  ulm_status #(.DEPTH(4), .CHAR_CYCLES(20)) ulm_status_i (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rx_done(rx_done), .rx_char(rx_char), .rx_line(rx_line),
    .rx_parity_bad(rx_parity_bad), .rx_stop_bit(rx_stop_bit), .dsr_n(dsr_n),
    .line_status_irq(ls_irq), .modem_status_irq(ms_irq));
  ulm_peer ulm_peer_i (.clock(clock), .rx_done(rx_done), .rx_char(rx_char),
    .rx_parity_bad(rx_parity_bad), .rx_stop_bit(rx_stop_bit), .rx_line(rx_line),
    .dsr_n(dsr_n));
  // Compare, register access and verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(what, {4{e}}, reg_rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic irqs(input logic [1:0] e);
    #1 chk("irq", {30'h0, e}, {30'h0, ms_irq, ls_irq});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  // Test sequence
  initial begin
    rst       <= 1'b1;
    reg_addr  <= 8'h00;
    reg_wdata <= 8'h00;
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(OFS_IER, 8'h00, "ier");
    rd(OFS_LSR, 8'h00, "lsr");
    wr(OFS_LSR, 8'hff);
    rd(OFS_LSR, 8'h00, "lsr_wr");
    rd(OFS_MSR, 8'h00, "msr");
    wr(OFS_MSR, 8'hff);
    rd(OFS_MSR, 8'h00, "msr_wr");
    rd(8'h08, 8'h00, "unmapped");
    wr(OFS_IER, 8'h0c);
    rd(OFS_IER, 8'h0c, "ier");
    ulm_peer_i.send(8'h55, 1'b1, 1'b0);
    repeat (2) @(posedge clock);
    irqs(2'b01);
    rd(OFS_LSR, 8'h05, "lsr_pe");
    irqs(2'b00);
    rd(OFS_LSR, 8'h01, "lsr_clr");
    ulm_peer_i.send(8'ha3, 1'b0, 1'b1);
    repeat (2) @(posedge clock);
    rd(OFS_LSR, 8'h01, "lsr_head");
    rd(OFS_RBR, 8'h55, "rbr");
    rd(OFS_LSR, 8'h09, "lsr_fe");
    rd(OFS_RBR, 8'ha3, "rbr");
    rd(OFS_LSR, 8'h00, "lsr_empty");
    for (int i = 0; i < 4; i++) ulm_peer_i.send(8'h10 + i[7:0], 1'b0, 1'b0);
    repeat (2) @(posedge clock);
    rd(OFS_LSR, 8'h01, "lsr_full");
    ulm_peer_i.send(8'h99, 1'b0, 1'b0);
    rd(OFS_LSR, 8'h03, "lsr_oe");
    for (int i = 0; i < 4; i++) rd(OFS_RBR, 8'h10 + i[7:0], "rbr_order");
    rd(OFS_LSR, 8'h00, "lsr_drain");
    ulm_peer_i.brk(10);
    repeat (3) @(posedge clock);
    rd(OFS_LSR, 8'h00, "lsr_short");
    ulm_peer_i.brk(25);
    repeat (3) @(posedge clock);
    rd(OFS_LSR, 8'h11, "lsr_brk");
    rd(OFS_RBR, 8'h00, "rbr_brk");
    ulm_peer_i.dsr(1'b0);
    repeat (6) @(posedge clock);
    irqs(2'b10);
    rd(OFS_MSR, 8'h22, "msr_chg");
    rd(OFS_MSR, 8'h20, "msr_clr");
    irqs(2'b00);
    wr(OFS_IER, 8'h04);
    ulm_peer_i.dsr(1'b1);
    repeat (6) @(posedge clock);
    irqs(2'b00);
    rd(OFS_MSR, 8'h02, "msr_rise");
    stop_test();
  end
endmodule
bind ulm_status ulm_status_props ulm_status_props_i (.clock(clock), .rst(rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_done(rx_done),
  .rx_line(rx_line), .dsr_n(dsr_n), .line_status_irq(line_status_irq));
`default_nettype wire
